// ### logic/sdi_pkg.sv
package sdi_pkg;
  localparam int WORD_BITS     = 16;
  localparam int BYTE_BITS     = 8;
  localparam int OVERSAMPLE    = 16;
  localparam int MID_SAMPLE    = 7;
  localparam int MAX_BAUD_KBPS = 150;
  localparam int MAX_OSC_KHZ   = 2400;
  localparam logic [15:0] WORD_RESET = 16'h0000;
endpackage

// ### logic/sdi_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface sdi_link_if;
  logic sclk;
  logic sdata;
  logic strobe;
  logic strobe_oe;
  logic sdout;
  logic strobe_pin;
  assign strobe_pin = strobe_oe ? strobe : 1'b1;
  modport host (
    output sclk,
    output sdata,
    output strobe,
    output strobe_oe,
    input  sdout
  );
  modport dev (
    input  sclk,
    input  sdata,
    input  strobe_pin,
    output sdout
  );
endinterface
`default_nettype wire

// ### logic/sdi_dev.sv
`timescale 1ns/1ps
`default_nettype none
module sdi_dev #(
  parameter int WIDTH = sdi_pkg::WORD_BITS
) (
  // Link clock and reset
  input  wire logic             i_lclk,
  input  wire logic             i_rst_n,
  input  wire logic             i_ce,
  // Link pins
  sdi_link_if.dev               link,
  // Framed mode select, tie high when strobe pin is pulled up
  input  wire logic             i_async_mode,
  // Latched word
  output logic [WIDTH-1:0]      o_word,
  output logic                  o_update
);
  typedef enum logic [1:0] {
    SDI_IDLE  = 2'b00,
    SDI_START = 2'b01,
    SDI_DATA  = 2'b10,
    SDI_STOP  = 2'b11
  } sdi_state_t;

  logic [WIDTH-1:0] shift_reg;
  logic [1:0]       strb_sync_reg;
  logic [1:0]       din_sync_reg;
  logic [1:0]       mode_sync_reg;
  logic             strb_prev_reg;
  sdi_state_t       state_reg;
  logic [3:0]       os_cnt_reg;
  logic [4:0]       bit_cnt_reg;
  logic [WIDTH-1:0] async_reg;
  logic             framed;

  // Three-wire path: shift on link clock rising edge
  always_ff @(posedge i_lclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      shift_reg <= sdi_pkg::WORD_RESET;
    end else if (i_ce && !framed && !link.strobe_pin) begin
      shift_reg <= {shift_reg[WIDTH-2:0], link.sdata};
    end
  end

  assign link.sdout = shift_reg[WIDTH-1];

  // Pin synchronisers for framed mode
  always_ff @(posedge i_lclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      strb_sync_reg <= 2'b11;
      din_sync_reg  <= 2'b11;
      mode_sync_reg <= 2'b00;
    end else if (i_ce) begin
      strb_sync_reg <= {strb_sync_reg[0], link.strobe_pin};
      din_sync_reg  <= {din_sync_reg[0], link.sdata};
      mode_sync_reg <= {mode_sync_reg[0], i_async_mode};
    end
  end

  assign framed = mode_sync_reg[1] && strb_sync_reg[1];

  // Strobe edge held in link domain
  always_ff @(posedge i_lclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      strb_prev_reg <= 1'b1;
    end else if (i_ce) begin
      strb_prev_reg <= link.strobe_pin;
    end
  end

  // Oversampled framed receiver
  always_ff @(posedge i_lclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg   <= SDI_IDLE;
      os_cnt_reg  <= 4'h0;
      bit_cnt_reg <= 5'h00;
      async_reg   <= sdi_pkg::WORD_RESET;
    end else if (i_ce) begin
      case (state_reg)
        SDI_IDLE: begin
          os_cnt_reg  <= 4'h0;
          bit_cnt_reg <= 5'h00;
          if (framed && !din_sync_reg[1]) begin
            state_reg <= SDI_START;
          end
        end
        SDI_START: begin
          os_cnt_reg <= os_cnt_reg + 4'h1;
          if (os_cnt_reg == 4'(sdi_pkg::MID_SAMPLE)) begin
            os_cnt_reg <= 4'h0;
            state_reg  <= din_sync_reg[1] ? SDI_IDLE : SDI_DATA;
          end
        end
        SDI_DATA: begin
          os_cnt_reg <= os_cnt_reg + 4'h1;
          if (os_cnt_reg == 4'(sdi_pkg::OVERSAMPLE - 1)) begin
            async_reg   <= {async_reg[WIDTH-2:0], din_sync_reg[1]};
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
            if (bit_cnt_reg == 5'(WIDTH - 1)) begin
              state_reg <= SDI_STOP;
            end
          end
        end
        SDI_STOP: begin
          os_cnt_reg <= os_cnt_reg + 4'h1;
          if (os_cnt_reg == 4'(sdi_pkg::OVERSAMPLE - 1)) begin
            state_reg <= SDI_IDLE;
          end
        end
        default: begin
          state_reg <= SDI_IDLE;
        end
      endcase
    end
  end

  // Latch update
  always_ff @(posedge i_lclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_word   <= sdi_pkg::WORD_RESET;
      o_update <= 1'b0;
    end else if (i_ce) begin
      o_update <= 1'b0;
      if (!framed && link.strobe_pin && !strb_prev_reg) begin
        o_word   <= shift_reg;
        o_update <= 1'b1;
      end else if (state_reg == SDI_STOP && os_cnt_reg == 4'(sdi_pkg::OVERSAMPLE - 1)
                   && din_sync_reg[1]) begin
        o_word   <= async_reg;
        o_update <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ### logic/sdi_host.sv
`timescale 1ns/1ps
`default_nettype none
module sdi_host #(
  parameter int WIDTH = sdi_pkg::WORD_BITS,
  parameter int DIV   = 2
) (
  // System clock and reset
  input  wire logic             i_mclk,
  input  wire logic             i_rst_n,
  input  wire logic             i_ce,
  // Request
  input  wire logic             i_start,
  input  wire logic [WIDTH-1:0] i_data,
  output logic                  o_busy,
  // Link pins
  sdi_link_if.host              link
);
  typedef enum logic [1:0] {
    SDH_IDLE  = 2'b00,
    SDH_SHIFT = 2'b01,
    SDH_LOAD  = 2'b10
  } sdh_state_t;

  sdh_state_t       state_reg;
  logic [WIDTH-1:0] data_reg;
  logic [4:0]       bit_cnt_reg;
  logic [7:0]       div_reg;
  logic             sclk_reg;
  logic             strobe_reg;

  assign o_busy         = state_reg != SDH_IDLE;
  assign link.sclk      = sclk_reg;
  assign link.sdata     = data_reg[WIDTH-1];
  assign link.strobe    = strobe_reg;
  assign link.strobe_oe = 1'b1;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg   <= SDH_IDLE;
      data_reg    <= sdi_pkg::WORD_RESET;
      bit_cnt_reg <= 5'h00;
      div_reg     <= 8'h00;
      sclk_reg    <= 1'b0;
      strobe_reg  <= 1'b1;
    end else if (i_ce) begin
      case (state_reg)
        SDH_IDLE: begin
          sclk_reg <= 1'b0;
          if (i_start) begin
            data_reg    <= i_data;
            strobe_reg  <= 1'b0;
            bit_cnt_reg <= 5'h00;
            div_reg     <= 8'h00;
            state_reg   <= SDH_SHIFT;
          end
        end
        SDH_SHIFT: begin
          div_reg <= div_reg + 8'h01;
          if (div_reg == 8'(DIV - 1)) begin
            div_reg  <= 8'h00;
            sclk_reg <= !sclk_reg;
            if (sclk_reg) begin
              data_reg    <= {data_reg[WIDTH-2:0], 1'b0};
              bit_cnt_reg <= bit_cnt_reg + 5'h01;
              if (bit_cnt_reg == 5'(WIDTH - 1)) begin
                state_reg <= SDH_LOAD;
              end
            end
          end
        end
        SDH_LOAD: begin
          sclk_reg   <= 1'b0;
          strobe_reg <= 1'b1;
          state_reg  <= SDH_IDLE;
        end
        default: begin
          state_reg <= SDH_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ### tb/sdi_link_properties.sv
`timescale 1ns/1ps
`default_nettype none
module sdi_link_properties #(
  parameter int WIDTH = 16
) (
  // Clock, reset, link
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic sclk,
  input wire logic sdata,
  input wire logic strobe,
  input wire logic strobe_oe,
  input wire logic sdout
);
  logic [7:0] rises;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) rises <= 8'h00;
    else if (strobe) rises <= 8'h00;
    else if ($rose(sclk)) rises <= rises + 8'h01;
  end
  property p_oe; strobe_oe; endproperty
  a_oe: assert property (p_oe) else $error("strobe undriven");
  property p_low; $rose(sclk) |-> !strobe; endproperty
  a_low: assert property (p_low) else $error("shift without strobe low");
  property p_idle; strobe |-> !sclk; endproperty
  a_idle: assert property (p_idle) else $error("clock active at load");
  property p_valid; $rose(sclk) |-> $stable(sdata); endproperty
  a_valid: assert property (p_valid) else $error("data moved at rise");
  property p_rate; $rose(sclk) |=> sclk ##1 !sclk; endproperty
  a_rate: assert property (p_rate) else $error("clock rate");
  property p_count; $rose(strobe) |-> rises == WIDTH; endproperty
  a_count: assert property (p_count) else $error("bit count");
  property p_bound; $fell(strobe) |-> ##[1:300] $rose(strobe); endproperty
  a_bound: assert property (p_bound) else $error("no load");
  property p_shift; !strobe && !sclk && !$past(sclk) |-> $stable(sdout); endproperty
  a_shift: assert property (p_shift) else $error("out moved off edge");
  c_load: cover property ($rose(strobe));
  c_frame: cover property ($fell(strobe));
  c_out: cover property ($rose(sdout));
endmodule
`default_nettype wire

// ### tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic i_mclk = 0, fclk = 0, i_rst_n = 0, i_ce = 1, i_start = 0, ser = 1;
  logic [31:0] i_data = 32'h0;
  logic [15:0] w1, w2, w3;
  logic lclk, o_busy, oclk = 0, u1, u3;
  int bad_count = 0, comparisons = 0, cyc = 0, seed = 25875, i, odiv = 0, n1 = 0, n3 = 0;
  sdi_link_if l1 ();
  sdi_link_if l2 ();
  sdi_link_if l3 ();
  assign #1 lclk = o_busy ? l1.sclk : fclk;
  assign l2.sclk = l1.sclk;
  assign l2.sdata = l1.sdout;
  assign l2.strobe = l1.strobe;
  assign l2.strobe_oe = l1.strobe_oe;
  assign l3.sclk = oclk;
  assign l3.sdata = ser;
  assign l3.strobe = 1'b0;
  assign l3.strobe_oe = 1'b0;
  sdi_host #(.WIDTH(32)) sdi_host_inst (.i_mclk, .i_rst_n, .i_ce, .i_start, .i_data, .o_busy, .link(l1));
  sdi_dev sdi_dev_inst (.i_lclk(lclk), .i_rst_n, .i_ce, .link(l1), .i_async_mode(1'b0), .o_word(w1), .o_update(u1));
  sdi_dev sdi_dev_inst2 (.i_lclk(lclk), .i_rst_n, .i_ce, .link(l2), .i_async_mode(1'b0), .o_word(w2), .o_update());
  sdi_dev sdi_dev_inst3 (.i_lclk(oclk), .i_rst_n, .i_ce, .link(l3), .i_async_mode(1'b1), .o_word(w3), .o_update(u3));
  sdi_link_properties #(.WIDTH(32)) sdi_link_properties_inst (.i_mclk, .i_rst_n, .sclk(l1.sclk),
    .sdata(l1.sdata), .strobe(l1.strobe), .strobe_oe(l1.strobe_oe), .sdout(l1.sdout));
  initial begin
    forever #20 i_mclk = ~i_mclk;
  end
  initial begin
    forever #15 fclk = ~fclk;
  end
  always @(posedge fclk) begin
    if (odiv == 6) begin
      odiv <= 0;
      oclk <= ~oclk;
    end else begin
      odiv <= odiv + 1;
    end
  end
  always @(posedge lclk) begin
    if (u1 === 1'b1) n1++;
  end
  always @(posedge oclk) begin
    if (u3 === 1'b1) n3++;
  end
  function automatic logic [15:0] slot(input logic [31:0] d, input int k);
    return d[16*k +: 16];
  endfunction
  task check(input string n, input logic [15:0] s, input logic [15:0] e);
    comparisons++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH %s exp %h seen %h", n, e, s);
    end
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task send(input logic [31:0] d);
    int t, k;
    k = n1;
    @(negedge i_mclk) {i_data, i_start} = {d, 1'b1};
    @(negedge i_mclk) i_start = 0;
    @(negedge i_mclk) {i_data, i_start} = {~d, 1'b1};
    @(negedge i_mclk) i_start = 0;
    for (t = 0; t < 400 && o_busy !== 1'b0; t++) @(negedge i_mclk);
    if (t == 400) bad_count++;
    repeat (6) @(negedge i_mclk);
    check("near", w1, slot(d, 0));
    check("far", w2, slot(d, 1));
    check("update", 16'(n1 - k), 16'h0001);
    $display("chain done %h", d);
  endtask
  task frame(input logic [15:0] w);
    int b, k;
    k = n3;
    for (b = 0; b < 18; b++) begin
      @(negedge oclk) ser = b == 0 ? 1'b0 : b == 17 ? 1'b1 : w[16-b];
      repeat (15) @(negedge oclk);
    end
    repeat (40) @(negedge oclk);
    check("framed", w3, w);
    check("frame_update", 16'(n3 - k), 16'h0001);
    $display("framed done %h", w);
  endtask
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      give_verdict();
    end
  end
  initial begin
    repeat (20) @(negedge i_mclk);
    i_rst_n = 1;
    for (i = 0; i < 8; i++) send(i == 0 ? 32'h0000FFFF : i == 1 ? 32'hFFFF8001 : $random(seed));
    frame(16'hA55A);
    frame(16'h0001);
    frame(16'($random(seed)));
    give_verdict();
  end
endmodule
`default_nettype wire
